// File: hdl/spi_port.v
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "spi_port_defs.vh"

// Function
// - master flags fault when its select input is driven low by another party.
// - fault clears master bit and four direction bits, then requests interrupt.
// - data write during transfer sets clash flag; byte discarded, transfer continues.
// - clash detection works in both master and slave roles.
// - master transfer busy from data write until done flag sets.
// - slave phase zero busy select low to high; done mid eighth cycle.
// - slave phase one busy from first active clock edge until done sets.
// - interrupt when done or fault flag set, enable one, cpu mask clear.
// - enabled port owns four pins; inputs forced, outputs need direction bit.
// - master select pin direction zero detects fault, one makes general output.
// - open drain bit makes the four pin buffers open drain.
// - idle master clock rests at the polarity bit level.
// - rate select divides clock by 2,4,16,32,8,16,64,128.
// - top rate bit lives in option register two, resets to zero.
// - done flag clears after status read seeing it, then data access.
// - data writes blocked until status read while done flag set.
// - clash flag clears after status read seeing it, then data access.
// - fault flag clears after status read seeing it, then control write.
// - status bits 5 and 3..0 read zero; status resets to zero.
// - only master data write starts transfer; done set in both roles.
// - data reads return receive buffer; uncleared done blocks the next master byte, a slave byte still overwrites it.
// - bit order option shifts lsb first; register keeps msb at bit 7.
// - extra rate bit adds divide by four ahead of the divider.
module spi_port (
  // clock and reset
  input  wire       sys_clk,
  input  wire       nrst,
  // register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // cpu interrupt mask and request
  input  wire       cpu_irq_mask,
  output wire       irq,
  // serial pins, two way, enable low drives
  input  wire       miso_in,
  output wire       miso_out,
  output wire       miso_oe_n,
  input  wire       mosi_in,
  output wire       mosi_out,
  output wire       mosi_oe_n,
  input  wire       sck_in,
  output wire       sck_out,
  output wire       sck_oe_n,
  input  wire       sel_in,
  output wire       sel_out,
  output wire       sel_oe_n,
  // general purpose drive for the select pin
  input  wire       sel_gp_level,
  // pins handed to general port when off
  output wire       pins_owned
);

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0] shift_control_reg;
  reg  [7:0] option_reg_two;
  reg  [7:0] port_direction_reg;
  reg        xfer_done_flag;
  reg        write_clash_flag;
  reg        multi_master_fault;
  reg  [7:0] rx_buf;
  reg  [7:0] shifter;
  reg        done_seen;
  reg        clash_seen;
  reg        fault_seen;
  reg        busy;
  reg  [2:0] bit_cnt;
  reg  [7:0] div_cnt;
  reg        sck_level;
  reg        half;
  reg        in_bit;
  reg        sel_s1;
  reg        sel_s2;
  reg        sck_s1;
  reg        sck_s2;
  reg        sck_prev;
  reg        sel_prev;
  reg  [7:0] next_ratio;

  wire serial_port_on    = shift_control_reg[`CTL_PORT_ON];
  wire master_select     = shift_control_reg[`CTL_MASTER];
  wire clock_idle_level  = shift_control_reg[`CTL_IDLE_LVL];
  wire clock_edge_phase  = shift_control_reg[`CTL_PHASE];
  wire open_drain_select = shift_control_reg[`CTL_OPEN_DRAIN];
  wire bit_order_select  = option_reg_two[`OPT_ORDER];
  wire select_pin_direction = port_direction_reg[`DIR_SEL];
  wire [2:0] rate_sel = {option_reg_two[`OPT_PRESCALE],
                         shift_control_reg[`CTL_RATE_HI], shift_control_reg[`CTL_RATE_LO]};

  wire is_master  = serial_port_on & master_select;
  wire is_slave   = serial_port_on & ~master_select;
  wire wr_ctl     = wr & (addr == `ADDR_CONTROL);
  wire wr_data    = wr & (addr == `ADDR_DATA);
  wire rd_data    = rd & (addr == `ADDR_DATA);
  wire rd_status  = rd & (addr == `ADDR_STATUS);
  wire acc_data   = wr_data | rd_data;
  wire tx_bit     = bit_order_select ? shifter[0] : shifter[7];

  // ****************************************
  // rate divider
  // ****************************************
  // one table covers prescale, 100 is the 2 ratio behind the divide by four
  always @*
  begin
    case (rate_sel)
      3'b000:  next_ratio = `DIV_R0;
      3'b001:  next_ratio = `DIV_R1;
      3'b010:  next_ratio = `DIV_R2;
      3'b011:  next_ratio = `DIV_R3;
      3'b100:  next_ratio = `DIV_R4;
      3'b101:  next_ratio = `DIV_R5;
      3'b110:  next_ratio = `DIV_R6;
      3'b111:  next_ratio = `DIV_R7;
      default: next_ratio = `DIV_R0;
    endcase
  end

  // one-cycle tick per serial clock half period
  wire [7:0] half_ratio = {1'b0, next_ratio[7:1]};
  wire       half_tick  = busy & is_master & (div_cnt == half_ratio - 8'd1);

  // ****************************************
  // input synchronisers
  // ****************************************
  // only sel_s2/sck_s2 and their delayed copies sel_prev/sck_prev feed logic, the first stage stays private
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_s1   <= 1'b1;
      sel_s2   <= 1'b1;
      sck_s1   <= 1'b0;
      sck_s2   <= 1'b0;
      sck_prev <= 1'b0;
      sel_prev <= 1'b1;
    end
    else
    begin
      sel_s1   <= sel_in;
      sel_s2   <= sel_s1;
      sck_s1   <= sck_in;
      sck_s2   <= sck_s1;
      sck_prev <= sck_s2;
      sel_prev <= sel_s2;
    end
  end

  // slave edges, active edge leaves the idle level
  wire sck_lead  = (sck_s2 != sck_prev) & (sck_prev == clock_idle_level);
  wire sck_trail = (sck_s2 != sck_prev) & (sck_prev != clock_idle_level);
  wire sel_low   = ~sel_s2;
  wire sel_fall  = sel_prev & ~sel_s2;
  wire sel_rise  = ~sel_prev & sel_s2;
  // sample on leading edge in phase zero, trailing in phase one
  wire s_sample  = is_slave & sel_low & (clock_edge_phase ? sck_trail : sck_lead);
  wire s_shift   = is_slave & sel_low & (clock_edge_phase ? sck_lead : sck_trail);
  wire fault_hit = is_master & ~select_pin_direction & sel_low;
  wire set_done;

  // ****************************************
  // transfer engine
  // ****************************************
  // master toggles sck each half tick; slave follows synced pins
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy      <= 1'b0;
      bit_cnt   <= 3'd0;
      div_cnt   <= 8'h00;
      sck_level <= 1'b0;
      half      <= 1'b0;
      in_bit    <= 1'b0;
      shifter   <= 8'h00;
      rx_buf    <= 8'h00;
    end
    else if (!serial_port_on)
    begin
      busy      <= 1'b0;
      bit_cnt   <= 3'd0;
      div_cnt   <= 8'h00;
      half      <= 1'b0;
      sck_level <= clock_idle_level;
    end
    else if (wr_data & ~busy & ~(xfer_done_flag & ~done_seen))
    begin
      shifter <= wdata;
      if (is_master)
      begin
        busy      <= 1'b1;
        bit_cnt   <= 3'd0;
        div_cnt   <= 8'h00;
        half      <= 1'b0;
      end
    end
    else if (is_master)
    begin
      if (!busy)
        sck_level <= clock_idle_level;
      else if (half_tick)
      begin
        div_cnt <= 8'h00;
        half    <= ~half;
        // every half tick moves the clock; master data keeps phase zero timing
        sck_level <= ~sck_level;
        if (!half)
          in_bit <= miso_in;
        else
        begin
          shifter <= bit_order_select ? {in_bit, shifter[7:1]} : {shifter[6:0], in_bit};
          bit_cnt <= bit_cnt + 3'd1;
          if (bit_cnt == 3'd7)
          begin
            busy   <= 1'b0;
            rx_buf <= bit_order_select ? {in_bit, shifter[7:1]} : {shifter[6:0], in_bit};
          end
        end
      end
      else
        div_cnt <= div_cnt + 8'd1;
    end
    else
    begin
      // slave busy window per phase
      if (!clock_edge_phase & sel_fall)
        busy <= 1'b1;
      else if (!clock_edge_phase & sel_rise)
        busy <= 1'b0;
      else if (clock_edge_phase & sck_lead & sel_low & ~busy)
        busy <= 1'b1;
      else if (clock_edge_phase & set_done)
        busy <= 1'b0;
      if (sel_rise)
        bit_cnt <= 3'd0;
      // eighth sample ends the byte, mid eighth cycle in phase zero
      if (s_sample)
      begin
        in_bit  <= mosi_in;
        bit_cnt <= bit_cnt + 3'd1;
        if (bit_cnt == 3'd7)
          rx_buf <= bit_order_select ? {mosi_in, shifter[7:1]} : {shifter[6:0], mosi_in};
      end
      // phase one keeps the first bit out through its opening edge, busy still low
      if (s_shift & busy)
        shifter <= bit_order_select ? {in_bit, shifter[7:1]} : {shifter[6:0], in_bit};
    end
  end

  // byte done pulse: master last half tick, slave eighth sample
  assign set_done = (is_master & busy & half_tick & half & (bit_cnt == 3'd7))
                  | (s_sample & (bit_cnt == 3'd7));

  // ****************************************
  // control, option and direction registers
  // ****************************************
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_control_reg  <= `CTL_RESET;
      option_reg_two     <= `OPT_RESET;
      port_direction_reg <= `DIR_RESET;
    end
    else
    begin
      if (wr_ctl)
        shift_control_reg <= wdata;
      if (wr & (addr == `ADDR_OPTION2))
        option_reg_two <= wdata & `OPT_RW_MASK;
      if (wr & (addr == `ADDR_DIRECTION))
        port_direction_reg <= wdata;
      // fault wins over the same-cycle software write, drivers must drop
      if (fault_hit)
      begin
        shift_control_reg[`CTL_MASTER] <= 1'b0;
        port_direction_reg[5:2]        <= 4'h0;
      end
    end
  end

  // ****************************************
  // status flags and clear sequences
  // ****************************************
  // set beats clear when both land in one cycle
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      xfer_done_flag     <= 1'b0;
      write_clash_flag   <= 1'b0;
      multi_master_fault <= 1'b0;
      done_seen          <= 1'b0;
      clash_seen         <= 1'b0;
      fault_seen         <= 1'b0;
    end
    else
    begin
      if (rd_status)
      begin
        done_seen  <= xfer_done_flag;
        clash_seen <= write_clash_flag;
        fault_seen <= multi_master_fault;
      end
      if (set_done)
        xfer_done_flag <= 1'b1;
      else if (acc_data & done_seen)
      begin
        xfer_done_flag <= 1'b0;
        done_seen      <= 1'b0;
      end
      if (wr_data & busy)
        write_clash_flag <= 1'b1;
      else if (acc_data & clash_seen)
      begin
        write_clash_flag <= 1'b0;
        clash_seen       <= 1'b0;
      end
      if (fault_hit)
        multi_master_fault <= 1'b1;
      else if (wr_ctl & fault_seen)
      begin
        multi_master_fault <= 1'b0;
        fault_seen         <= 1'b0;
      end
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  // unmapped addresses answer zero
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `ADDR_CONTROL:   rdata <= shift_control_reg;
        `ADDR_STATUS:    rdata <= {xfer_done_flag, write_clash_flag, 1'b0,
                                   multi_master_fault, 4'h0};
        `ADDR_DATA:      rdata <= rx_buf;
        `ADDR_OPTION2:   rdata <= option_reg_two;
        `ADDR_DIRECTION: rdata <= port_direction_reg;
        default:         rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // level request, dropped by the flag sequences, by cpu_irq_mask or by clearing the enable bit
  assign irq = shift_control_reg[`CTL_IRQ_EN] & ~cpu_irq_mask
             & (xfer_done_flag | multi_master_fault);

  // ****************************************
  // pin ownership and drivers
  // ****************************************
  // open drain mode only ever drives a low, never a high
  wire miso_drv = is_slave & sel_low & port_direction_reg[`DIR_MISO];
  wire mosi_drv = is_master & port_direction_reg[`DIR_MOSI];
  wire sck_drv  = is_master & port_direction_reg[`DIR_SCK];
  wire sel_drv  = is_master & select_pin_direction;
  assign pins_owned = serial_port_on;
  assign miso_out  = tx_bit;
  assign mosi_out  = tx_bit;
  assign sck_out   = sck_level;
  assign sel_out   = sel_gp_level;
  assign miso_oe_n = ~(miso_drv & ~(open_drain_select & tx_bit));
  assign mosi_oe_n = ~(mosi_drv & ~(open_drain_select & tx_bit));
  assign sck_oe_n  = ~(sck_drv & ~(open_drain_select & sck_level));
  assign sel_oe_n  = ~(sel_drv & ~(open_drain_select & sel_gp_level));

endmodule

// File: include/spi_port_defs.vh
`ifndef SPI_PORT_DEFS_VH
`define SPI_PORT_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_CONTROL   8'h28
`define ADDR_STATUS    8'h29
`define ADDR_DATA      8'h2A
`define ADDR_OPTION2   8'h38
`define ADDR_DIRECTION 8'h09

// ****************************************
// control register fields
// ****************************************
`define CTL_IRQ_EN     7
`define CTL_PORT_ON    6
`define CTL_OPEN_DRAIN 5
`define CTL_MASTER     4
`define CTL_IDLE_LVL   3
`define CTL_PHASE      2
`define CTL_RATE_HI    1
`define CTL_RATE_LO    0
`define CTL_RESET      8'h04

// ****************************************
// status register fields
// ****************************************
`define STS_DONE       7
`define STS_CLASH      6
`define STS_FAULT      4
`define STS_RESET      8'h00

// ****************************************
// option register two fields
// ****************************************
`define OPT_ORDER      3
`define OPT_PRESCALE   2
`define OPT_RW_MASK    8'hFC
`define OPT_RESET      8'h00

// ****************************************
// direction register bits for the four pins
// ****************************************
`define DIR_MISO       2
`define DIR_MOSI       3
`define DIR_SCK        4
`define DIR_SEL        5
`define DIR_RESET      8'h00

// ****************************************
// divider ratios, full serial clock periods
// ****************************************
`define DIV_R0         8'd2
`define DIV_R1         8'd4
`define DIV_R2         8'd16
`define DIV_R3         8'd32
`define DIV_R4         8'd8
`define DIV_R5         8'd16
`define DIV_R6         8'd64
`define DIV_R7         8'd128

`endif

// File: testbench/spi_port_assertions.sv
`timescale 1ns/1ps
// ********
// port checks for the serial block
// ********
module spi_port_chk (
  // clock and reset
  input wire       sys_clk,
  input wire       nrst,
  // register port
  input wire [7:0] addr,
  input wire       rd,
  input wire       wr,
  input wire [7:0] rdata,
  // interrupt
  input wire       cpu_irq_mask,
  input wire       irq,
  // pin controls
  input wire       miso_oe_n,
  input wire       mosi_oe_n,
  input wire       sck_oe_n,
  input wire       sel_in,
  input wire       sel_oe_n,
  input wire       pins_owned
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // rival master holds our select low while we drive the clock
  sequence rival_low;
    (pins_owned && !sck_oe_n && sel_oe_n && !sel_in) [*3];
  endsequence
  // our drivers let go soon after, so two masters never fight
  sequence drivers_off;
    ##[0:4] (mosi_oe_n && sck_oe_n);
  endsequence
  AST_FAULT_RELEASE: assert property (rival_low |-> drivers_off)
    else $error("fault left drivers on");
  AST_SYNC_DELAY: assert property (
    $fell(sel_in) && sel_oe_n && !sck_oe_n |=> !sck_oe_n)
    else $error("select acted before sync");
  AST_IRQ_MASKED: assert property (cpu_irq_mask |-> !irq)
    else $error("irq while masked");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> cpu_irq_mask || $past(wr) || $past(rd))
    else $error("irq dropped with no cause");
  AST_STS_ZERO: assert property (
    rd && addr == 8'h29 |=> rdata[5] == 1'h0 && rdata[3:0] == 4'h0)
    else $error("unused status bits set");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_MASTER_MISO_IN: assert property (pins_owned && !sck_oe_n |-> miso_oe_n)
    else $error("master drives its input pin");
  AST_SLAVE_SCK_IN: assert property (pins_owned && !miso_oe_n |-> sck_oe_n)
    else $error("slave drives the clock pin");
endmodule

bind spi_port spi_port_chk spi_port_chk_i (
  .sys_clk, .nrst, .addr, .rd, .wr, .rdata, .cpu_irq_mask, .irq,
  .miso_oe_n, .mosi_oe_n, .sck_oe_n, .sel_in, .sel_oe_n, .pins_owned
);

// File: testbench/spi_far_slave.sv
`timescale 1ns/1ps
// ********
// far side slave with a rival master on select
// ********
module spi_far_slave (
  // serial lines
  input  wire       sck,
  input  wire       pol,
  input  wire       mosi,
  output reg        miso = 1'h0,
  output wire       sel_n,
  // bench control
  input  wire       load,
  input  wire       fault,
  input  wire [7:0] tx_byte,
  output reg  [7:0] rx_byte = 8'h00
);
  reg  [7:0] sh;
  reg  [3:0] cnt;
  wire       lead = sck ^ pol;
  // a rival master pulls select low on command
  assign sel_n = !fault;
  // preload; first bit stands before the first leading edge
  always @(posedge load)
  begin
    sh = tx_byte;
    cnt = 4'h0;
    miso = tx_byte[7];
  end
  // capture on the leading edge
  always @(posedge lead)
    rx_byte = {rx_byte[6:0], mosi};
  // shift on trailing edge; past bit eight the line holds no data
  always @(negedge lead)
  begin
    sh = sh << 1;
    cnt = cnt + 4'h1;
    miso = (cnt == 4'h8) ? !miso : sh[7];
  end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ********
  // bench signals
  // ********
  reg        sys_clk = 0;
  reg        nrst = 0;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 0;
  reg        rd = 0;
  reg        cpu_irq_mask = 0;
  reg        sel_gp_level = 0;
  reg        tb_sck = 0;
  reg        tb_sel = 1;
  reg        tb_mosi = 0;
  reg        load = 0;
  reg        fault = 0;
  reg        pol = 0;
  reg  [7:0] tx_byte = 8'h00;
  reg  [7:0] v;
  reg  [7:0] c;
  integer    i;
  integer    n_errors = 0;
  integer    tests_run = 0;
  wire [7:0] rdata;
  wire [7:0] rx_byte;
  wire       irq, pins_owned, p_miso, p_sel_n;
  wire       miso_out, miso_oe_n, mosi_out, mosi_oe_n;
  wire       sck_out, sck_oe_n, sel_out, sel_oe_n;
  // pin levels; a rival on select wins low
  wire       miso_in = miso_oe_n ? p_miso : miso_out;
  wire       mosi_in = mosi_oe_n ? tb_mosi : mosi_out;
  wire       sck_in = sck_oe_n ? tb_sck : sck_out;
  wire       sel_in = p_sel_n & tb_sel & (sel_oe_n | sel_out);

  spi_port spi_port_i (
    .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cpu_irq_mask(cpu_irq_mask), .irq(irq),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .sel_in(sel_in), .sel_out(sel_out), .sel_oe_n(sel_oe_n),
    .sel_gp_level(sel_gp_level), .pins_owned(pins_owned));
  spi_far_slave spi_far_slave_i (
    .sck(sck_in), .pol(pol), .mosi(mosi_in), .miso(p_miso), .sel_n(p_sel_n),
    .load(load), .fault(fault), .tx_byte(tx_byte), .rx_byte(rx_byte));

  // clock
  initial
    forever #12.5 sys_clk = ~sys_clk;

  // ********
  // helpers
  // ********
  function integer ratio(input [2:0] s);
    ratio = (64'h8040_1008_2010_0402 >> (8 * s)) & 64'hFF;
  endfunction
  function [7:0] rev(input [7:0] d);
    integer j;
    for (j = 0; j < 8; j = j + 1)
      rev[j] = d[7 - j];
  endfunction
  task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("BAD %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // edge gap after each strobe keeps one driver per step
  task wr8(input [7:0] a, input [7:0] d);
  begin
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge sys_clk);
    wr <= 1'h0;
    @(posedge sys_clk);
  end
  endtask
  task rd8(input [7:0] a);
  begin
    addr <= a;
    rd <= 1'h1;
    @(posedge sys_clk);
    rd <= 1'h0;
    #1 v = rdata;
    @(posedge sys_clk);
  end
  endtask
  task summarize;
  begin
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // master byte; k 1 adds a clash, k 2 a write before the status read
  task xfer(input [1:0] k, input [2:0] s);
    reg       ord;
    reg [7:0] b, pb;
    integer   n, r;
  begin
    pol = $urandom;
    ord = $urandom;
    b = $urandom;
    pb = $urandom;
    r = ratio(s);
    sel_gp_level <= $urandom;
    tx_byte <= pb;
    wr8(8'h38, {4'h0, ord, s[2], 2'h0});
    wr8(8'h28, {4'hD, pol, 1'h0, s[1:0]});
    wr8(8'h09, 8'h38);
    #1 chk("idle", pol, sck_out);
    load <= 1'h1;
    fault <= 1'h1;
    @(posedge sys_clk);
    load <= 1'h0;
    wr8(8'h2A, b);
    n = (k == 1) ? 4 : 2;
    if (k == 1)
      wr8(8'h2A, ~b);
    #1;
    while (irq !== 1'h1 && n < 2000)
    begin
      @(posedge sys_clk);
      #1 n = n + 1;
    end
    chk("time", 8'h01, {7'h00, n >= 8 * r - r / 2 && n <= 8 * r + 8});
    chk("far", ord ? rev(b) : b, rx_byte);
    if (k == 2)
    begin
      wr8(8'h2A, ~b);
      repeat (8 * r) @(posedge sys_clk);
      chk("block", ord ? rev(b) : b, rx_byte);
    end
    cpu_irq_mask <= 1'h1;
    @(posedge sys_clk);
    #1 chk("mask", 8'h00, irq);
    cpu_irq_mask <= 1'h0;
    rd8(8'h29);
    chk("sts", {1'h1, k == 1, 6'h00}, v);
    rd8(8'h2A);
    chk("rx", ord ? rev(pb) : pb, v);
    rd8(8'h29);
    chk("clr", 8'h00, v);
    chk("irq", 8'h00, irq);
    fault <= 1'h0;
  end
  endtask

  // ********
  // main sequence
  // ********
  initial
  begin
    v = $urandom(95);
    repeat (10) @(posedge sys_clk);
    nrst <= 1'h1;
    @(posedge sys_clk);
    rd8(8'h29);
    chk("sts0", 8'h00, v);
    rd8(8'h38);
    chk("opt0", 8'h00, v);
    wr8(8'h38, 8'hFF);
    rd8(8'h38);
    chk("opt", 8'hFC, v);
    rd8(8'h00);
    chk("nomap", 8'h00, v);
    for (i = 0; i < 12; i = i + 1)
      xfer(i % 3, i);
    // rival master pulls select low
    wr8(8'h28, 8'hD0);
    wr8(8'h09, 8'h18);
    fault <= 1'h1;
    repeat (8) @(posedge sys_clk);
    #1 chk("irqf", 8'h01, irq);
    rd8(8'h29);
    chk("fault", 8'h10, v);
    rd8(8'h28);
    chk("ctlf", 8'hC0, v);
    rd8(8'h09);
    chk("dirf", 8'h00, v);
    fault <= 1'h0;
    // synced select must be high again before master comes back
    repeat (3) @(posedge sys_clk);
    wr8(8'h28, 8'hD0);
    rd8(8'h29);
    chk("fclr", 8'h00, v);
    // slave byte, mode zero, with a clash while selected
    wr8(8'h28, 8'hC0);
    wr8(8'h09, 8'h04);
    wr8(8'h38, 8'h00); // msb first, last master byte left the order random
    tx_byte = $urandom;
    wr8(8'h2A, 8'hC3);
    tb_sel <= 1'h0;
    repeat (4) @(posedge sys_clk);
    wr8(8'h2A, 8'h3C);
    for (i = 7; i >= 0; i = i - 1)
    begin
      tb_mosi <= tx_byte[i];
      repeat (8) @(posedge sys_clk);
      c[i] = miso_out;
      tb_sck <= 1'h1;
      repeat (8) @(posedge sys_clk);
      tb_sck <= 1'h0;
    end
    repeat (8) @(posedge sys_clk);
    chk("miso", 8'hC3, c);
    rd8(8'h29);
    chk("ssts", 8'hC0, v);
    rd8(8'h2A);
    chk("srx", tx_byte, v);
    tb_sel <= 1'h1;
    summarize;
  end

  // watchdog
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    summarize;
  end
endmodule
